// [logic/acst_ctrl.sv]
`timescale 1ns/10ps
module acst_ctrl
  import acst_pkg::*;
(
  input wire logic i_mclk, // 50 MHz system clock
  input wire logic i_reset, // sync reset, active high
  input wire logic i_cs_n, // chip select pin, active low
  input wire logic i_sclk, // serial clock pin
  input wire logic i_serial_in_line, // serial input pin
  input wire acst_sample_s i_sample, // analog core results
  input wire logic i_oversample_mode, // oversampling normal mode on
  input wire logic [1:0] i_os_ratio, // log2 of samples averaged
  input wire logic i_wide_variant, // 16-bit part, longer step
  input wire logic i_alert_on_lane_d, // lane d pin shows the flag
  input wire logic [RES_W-1:0] i_thresh_high, // upper limit
  input wire logic [RES_W-1:0] i_thresh_low, // lower limit
  output acst_lanes_s o_lanes, // lane pins and enables
  output logic o_alert_n, // out-of-range flag, active low
  output logic o_busy, // conversion in progress
  output logic [CMD_W-1:0] o_cmd_word, // word taken from input line
  output logic o_cmd_valid // one-cycle pulse per full word
);
  logic [2:0] pins_sync;
  acst_state_e state_q;
  acst_state_e state_d;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic [CNT_W-1:0] timer_q;
  logic [CNT_W-1:0] timer_d;
  acst_sample_s held_q;
  acst_sample_s result_q;
  acst_sample_s shift_q;
  acst_lanes_s lanes_q;
  logic alert_n_q;
  logic busy_q;
  logic [CMD_W-1:0] cmd_q;
  logic [BIT_W-1:0] cmd_cnt_q;
  logic [CMD_W-1:0] cmd_word_q;
  logic cmd_valid_q;

  // pins pass two flops before any logic reads them
  acst_sync #(.W(3), .INIT(PIN_IDLE)) u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_cs_n, i_sclk, i_serial_in_line}),
    .o_sync(pins_sync)
  );

  // edge decode on synchronised levels
  wire cs_n_s = pins_sync[2];
  wire sclk_s = pins_sync[1];
  wire sdi_s = pins_sync[0];
  wire cs_fall = cs_prev_q & ~cs_n_s;
  wire cs_rise = ~cs_prev_q & cs_n_s;
  wire sclk_rise = ~sclk_prev_q & sclk_s;
  wire sclk_fall = sclk_prev_q & ~sclk_s;
  wire conv_done = (state_q == ST_CONVERT) && (timer_q == CNT_ONE);

  // is any lane of a result outside the window
  function automatic logic out_of_range(input acst_sample_s s,
                                        input logic [RES_W-1:0] hi,
                                        input logic [RES_W-1:0] lo);
    logic r;
    r = 1'b0;
    for (int i = 0; i < LANES; i++) begin
      if (s[i*RES_W +: RES_W] > hi || s[i*RES_W +: RES_W] < lo) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : out_of_range

  // oversampled length: first plus (n-1) steps
  wire [CNT_W-1:0] step_cyc = i_wide_variant ? CYC_STEP_WIDE : CYC_STEP_NARROW;
  wire [3:0] os_count = 4'(1 << i_os_ratio);
  wire [CNT_W-1:0] os_steps = CNT_W'(os_count - 4'h1);
  wire [CNT_W-1:0] os_len = CNT_W'(CYC_CONVERT0 + os_steps * step_cyc);
  // first oversampled result after conv0 cycles
  wire [CNT_W-1:0] conv_len = i_oversample_mode ? os_len : CYC_CONVERT;

  // conversion sequencer; a new start mid-conversion restarts it,
  // the host owns the spacing between starts
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_CONVERT;
          timer_d = conv_len;
        end
      end
      ST_CONVERT: begin
        if (cs_fall) begin
          timer_d = conv_len;
        end else if (timer_q == CNT_ONE) begin
          state_d = ST_IDLE;
          timer_d = CNT_ZERO;
        end else begin
          timer_d = timer_q - CNT_ONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        timer_d = CNT_ZERO;
      end
    endcase
  end

  // state and edge history
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      timer_q <= CNT_ZERO;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      cs_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
      busy_q <= (state_d == ST_CONVERT);
    end
  end

  // all four inputs held together at the start
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      held_q <= '0;
      result_q <= '0;
    end else begin
      if (cs_fall) begin
        held_q <= i_sample;
      end
      if (conv_done) begin
        result_q <= held_q;
      end
    end
  end

  // readout holds the last finished result; shifts after sclk rise
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      shift_q <= '0;
    end else if (cs_fall) begin
      shift_q <= result_q;
    end else if (!cs_n_s && sclk_rise) begin
      shift_q <= {shift_q.d[RES_W-2:0], 1'b0, shift_q.c[RES_W-2:0], 1'b0,
                  shift_q.b[RES_W-2:0], 1'b0, shift_q.a[RES_W-2:0], 1'b0};
    end
  end

  // flag raised one cycle after an out-of-range result
  // flag dropped on the cycle after chip select falls
  // a set in the same cycle as a clear wins
  wire alert_set = conv_done && out_of_range(held_q, i_thresh_high, i_thresh_low);
  wire alert_n_d = alert_set ? 1'b0 : (cs_fall ? 1'b1 : alert_n_q);

  // flag kept active low in its own flop, no inverter on the pin
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      alert_n_q <= 1'b1;
    end else begin
      alert_n_q <= alert_n_d;
    end
  end

  // lanes driven only while chip select is low, save lane d in alert configuration
  // enables drop on the cycle after chip select rises
  // lane d pin shows the flag in alert configuration
  wire read_on = ~cs_n_s;
  wire lane_d_alert = i_alert_on_lane_d;
  wire [LANES-1:0] msb_bits = {shift_q.d[RES_W-1], shift_q.c[RES_W-1],
                               shift_q.b[RES_W-1], shift_q.a[RES_W-1]};
  wire [LANES-1:0] lane_dat_d = lane_d_alert ?
                                {alert_n_d, msb_bits[2:0] & {3{read_on}}} :
                                msb_bits & {LANES{read_on}};
  wire [LANES-1:0] lane_oe_d = lane_d_alert ? {1'b1, {3{read_on}}} : {LANES{read_on}};

  // registered pins so nothing glitches on the lanes
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lanes_q <= '0;
    end else begin
      lanes_q.dat <= lane_dat_d;
      lanes_q.oe <= lane_oe_d;
    end
  end

  // input line sampled on serial clock falling edges
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmd_q <= '0;
      cmd_cnt_q <= '0;
    end else if (cs_fall) begin
      cmd_cnt_q <= '0;
    end else if (!cs_n_s && sclk_fall && cmd_cnt_q != CMD_FULL) begin
      cmd_q <= {cmd_q[CMD_W-2:0], sdi_s};
      cmd_cnt_q <= cmd_cnt_q + BIT_W'(1);
    end
  end

  // a word is handed on only when the frame held all its bits;
  // short frames are dropped, extra bits are ignored
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmd_word_q <= '0;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= cs_rise && (cmd_cnt_q == CMD_FULL);
      if (cs_rise && (cmd_cnt_q == CMD_FULL)) begin
        cmd_word_q <= cmd_q;
      end
    end
  end

  assign o_lanes = lanes_q;
  assign o_alert_n = alert_n_q;
  assign o_busy = busy_q;
  assign o_cmd_word = cmd_word_q;
  assign o_cmd_valid = cmd_valid_q;
endmodule : acst_ctrl

// [logic/acst_pkg.sv]
package acst_pkg;
  // lane count and result width
  localparam int LANES = 4;
  localparam int RES_W = 16;
  localparam int CMD_W = 16;
  localparam int CNT_W = 8;
  localparam int BIT_W = 5;

  // clock rate and printed times
  localparam int CLK_MHZ = 50;
  localparam int T_CONVERT_NS = 190;
  localparam int T_CONVERT0_NS = 8;
  localparam int T_STEP_WIDE_NS = 320;
  localparam int T_STEP_NARROW_NS = 250;
  localparam int T_ALERT_SET_NS = 20;
  localparam int T_ALERT_CLR_NS = 10;

  // longest times round down, never under one cycle
  function automatic int max_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : max_cyc

  localparam logic [CNT_W-1:0] CYC_CONVERT = CNT_W'(max_cyc(T_CONVERT_NS));
  localparam logic [CNT_W-1:0] CYC_CONVERT0 = CNT_W'(max_cyc(T_CONVERT0_NS));
  localparam logic [CNT_W-1:0] CYC_STEP_WIDE = CNT_W'(max_cyc(T_STEP_WIDE_NS));
  localparam logic [CNT_W-1:0] CYC_STEP_NARROW = CNT_W'(max_cyc(T_STEP_NARROW_NS));
  localparam int CYC_ALERT_SET = max_cyc(T_ALERT_SET_NS);
  localparam int CYC_ALERT_CLR = max_cyc(T_ALERT_CLR_NS);

  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(RES_W - 1);
  localparam logic [BIT_W-1:0] CMD_FULL = BIT_W'(CMD_W);
  localparam logic [RES_W-1:0] RES_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  // pin levels at rest: chip select high, clock and input line low
  localparam logic [2:0] PIN_IDLE = 3'h4;

  // four simultaneous results
  typedef struct packed {
    logic [RES_W-1:0] d;
    logic [RES_W-1:0] c;
    logic [RES_W-1:0] b;
    logic [RES_W-1:0] a;
  } acst_sample_s;

  // serial lane pins: data and output enable
  typedef struct packed {
    logic [LANES-1:0] dat;
    logic [LANES-1:0] oe;
  } acst_lanes_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT
  } acst_state_e;
endpackage : acst_pkg

// [logic/acst_sync.sv]
`timescale 1ns/10ps
// two-flop synchroniser for pins from outside the clock domain
module acst_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic i_mclk, // system clock
  input wire logic i_reset, // sync reset, active high
  input wire logic [W-1:0] i_async, // raw pin levels
  output logic [W-1:0] o_sync // synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second; reset to the rest level
  // so edge detectors see no false edge once reset lifts
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : acst_sync

// [test/acst_ctrl_chk.sv]
`timescale 1ns/10ps
// watches lane enables, busy length, flag and word strobe
module acst_ctrl_chk
  import acst_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_reset, // sync reset
  input wire logic i_cs_n, // chip select pin
  input wire logic i_oversample_mode, // oversampling on
  input wire logic [1:0] i_os_ratio, // log2 samples
  input wire logic i_wide_variant, // long step
  input wire logic i_alert_on_lane_d, // lane d shows flag
  input wire acst_lanes_s o_lanes, // lane pins
  input wire logic o_alert_n, // flag, active low
  input wire logic o_busy, // conversion running
  input wire logic o_cmd_valid // word strobe
);
  int run_q;
  int len_w;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // expected busy length; inputs held steady over a conversion
  assign len_w = i_oversample_mode ? 1 + ((1 << i_os_ratio) - 1) * (i_wide_variant ? 16 : 12) : 9;
  // busy run counter, too long for a repetition
  always_ff @(posedge i_mclk) begin
    run_q <= (i_reset || !o_busy) ? 0 : run_q + 1;
  end
  sequence cs_fall_s; $fell(i_cs_n); endsequence
  sequence lanes_on_s; ##[1:5] (o_lanes.oe == 4'hF); endsequence
  AST_START: assert property ($fell(i_cs_n) && !o_busy |-> ##[1:5] o_busy)
    else $error("busy did not follow chip select fall");
  AST_LEN: assert property ($fell(o_busy) |-> run_q == len_w)
    else $error("conversion length wrong");
  AST_OE_ON: assert property (cs_fall_s |-> lanes_on_s)
    else $error("lanes not enabled");
  AST_SILENT: assert property (i_cs_n [*6] |-> o_lanes.oe[2:0] == 3'h0)
    else $error("lanes driven while deselected");
  AST_OE_OFF: assert property ($rose(i_cs_n) |-> ##[1:5] (o_lanes.oe[2:0] == 3'h0))
    else $error("lanes not released");
  AST_SET: assert property ($fell(o_alert_n) |-> $past(o_busy) || $past(o_busy, 2))
    else $error("flag set without a finished conversion");
  AST_CLR: assert property ($fell(i_cs_n) && !o_alert_n |-> ##[1:5] o_alert_n)
    else $error("flag not cleared");
  AST_LANE_D: assert property (i_alert_on_lane_d && $past(i_alert_on_lane_d)
    |-> o_lanes.oe[3] && (o_lanes.dat[3] == o_alert_n))
    else $error("lane d does not carry the flag");
  AST_VALID: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("word strobe longer than one cycle");
  AST_VALID_CS: assert property (o_cmd_valid |-> i_cs_n && $past(i_cs_n))
    else $error("word strobe inside a frame");
endmodule : acst_ctrl_chk

bind acst_ctrl acst_ctrl_chk u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_cs_n(i_cs_n),
  .i_oversample_mode(i_oversample_mode), .i_os_ratio(i_os_ratio),
  .i_wide_variant(i_wide_variant), .i_alert_on_lane_d(i_alert_on_lane_d),
  .o_lanes(o_lanes), .o_alert_n(o_alert_n), .o_busy(o_busy), .o_cmd_valid(o_cmd_valid));

// [test/acst_host.sv]
`timescale 1ns/10ps
// host side: chip select, serial clock and input line
module acst_host
  import acst_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire acst_lanes_s i_lanes, // lane pins
  output logic o_cs_n, // chip select
  output logic o_sclk, // serial clock, low outside frames
  output logic o_sdi, // serial input line
  output acst_sample_s o_rx // bits read per lane
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_rx = '0;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : tick
  // one frame of n clocks at 160 ns; bit read just before each rise
  task automatic frame(input int n, input logic [CMD_W-1:0] w);
    // quiet serial side before the start
    o_cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < n; i++) begin
      // a lane that is not driven reads back inverted
      for (int l = 0; l < LANES; l++) begin
        o_rx[RES_W*l + 15 - i] = i_lanes.oe[l] ? i_lanes.dat[l] : ~i_lanes.dat[l];
      end
      // line wrong at the rise, right by the fall
      o_sclk = 1'b1;
      o_sdi = ~w[CMD_W-1-i];
      tick(2);
      o_sdi = w[CMD_W-1-i];
      tick(2);
      o_sclk = 1'b0;
      tick(4);
    end
    o_cs_n = 1'b1;
    // released line shows a changed level, not the last bit
    o_sdi = ~o_sdi;
    // spacing covers alternating rate and soft reset wait
    tick(26);
  endtask : frame
endmodule : acst_host

// [test/adc_conversion_serial_timing_tb_top.sv]
`timescale 1ns/10ps
// drives the controller through its host model
module adc_conversion_serial_timing_tb_top;
  import acst_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset, os_mode, wide, flag_d, cs_n, sclk, serial_in_line, alert_n, busy, cvalid;
  logic [1:0] ratio;
  logic [RES_W-1:0] thr_hi, thr_lo;
  logic [CMD_W-1:0] cword;
  acst_sample_s smp, rx;
  acst_lanes_s lanes;
  int fails = 0, n_tests = 0, run = 0, len = 0, nval = 0;
  always #10 i_mclk = ~i_mclk;
  acst_host host (.i_mclk(i_mclk), .i_lanes(lanes), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdi(serial_in_line), .o_rx(rx));
  acst_ctrl dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_serial_in_line(serial_in_line), .i_sample(smp), .i_oversample_mode(os_mode),
    .i_os_ratio(ratio), .i_wide_variant(wide), .i_alert_on_lane_d(flag_d),
    .i_thresh_high(thr_hi), .i_thresh_low(thr_lo), .o_lanes(lanes), .o_alert_n(alert_n),
    .o_busy(busy), .o_cmd_word(cword), .o_cmd_valid(cvalid));
  // length of the last busy run, count of word strobes
  always @(posedge i_mclk) begin
    if (cvalid === 1'b1) nval <= nval + 1;
    if (busy === 1'b1) run <= run + 1;
    else if (run != 0) begin
      len <= run;
      run <= 0;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // word capture, short frame drop, readout of the previous result
  task automatic t_readout;
    smp = 64'h1234_5678_9ABC_DEF0;
    host.frame(16, 16'hA55A);
    chk(cword, 16'hA55A);
    chk(nval, 1);
    smp = 64'h8001_7FFE_C003_3FFC;
    host.frame(5, 16'h1234);
    chk(cword, 16'hA55A);
    chk(nval, 1);
    host.frame(16, 16'h0000);
    chk(rx, 64'h8001_7FFE_C003_3FFC);
    chk(lanes.oe, 4'h0);
  endtask : t_readout
  // every ratio on both step sizes, then plain timing
  task automatic t_oversample;
    os_mode = 1'b1;
    for (int r = 0; r < 4; r++) begin
      for (int w = 0; w < 2; w++) begin
        ratio = 2'(r);
        wide = w[0];
        host.frame(16, 16'h0000);
        chk(len, 1 + ((1 << r) - 1) * (w ? 16 : 12));
      end
    end
    os_mode = 1'b0;
    host.frame(16, 16'h0000);
    chk(len, 9);
  endtask : t_oversample
  // flag above and below the window, cleared by the next chip select fall, its conversion clean
  task automatic t_alert;
    thr_hi = 16'h8000;
    thr_lo = 16'h0100;
    flag_d = 1'b1;
    smp = {16'h0200, 16'hF000, 16'h0200, 16'h0200};
    host.frame(16, 16'h0000);
    chk(alert_n, 1'b0);
    chk({lanes.oe[3], lanes.dat[3]}, 2'h2);
    smp = {4{16'h0200}};
    host.frame(16, 16'h0000);
    chk(alert_n, 1'b1);
    smp = {16'h0200, 16'h0200, 16'h0200, 16'h0050};
    host.frame(16, 16'h0000);
    chk(alert_n, 1'b0);
  endtask : t_alert
  initial begin
    i_reset = 1'b1;
    {os_mode, wide, flag_d, ratio} = '0;
    thr_hi = 16'hFFFF;
    thr_lo = 16'h0000;
    smp = '0;
    repeat (6) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    // hard reset settling before the first start
    // no supply or shutdown pin here; this wait stands in
    repeat (40) @(posedge i_mclk);
    #1;
    t_readout();
    t_oversample();
    t_alert();
    close_out();
  end
endmodule : adc_conversion_serial_timing_tb_top
